// ==== smbus_host_model.sv ====
`timescale 1ns/1ps
// ====
// Host side: one-cycle strobes launched just after a rising edge
module smbus_host_model (
  input wire clk_sys,
  input wire [15:0] reg_rdata,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_ptr = 8'h00,
  output reg [15:0] reg_wdata = 16'h0000
);
  task wr(input [7:0] p, input [15:0] d);
    begin
      @(posedge clk_sys);
      #1 reg_wr = 1'b1;
      reg_ptr = p;
      reg_wdata = (p == 8'h01) ? (d & 16'h07ff) : d;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
    end
  endtask
  task rd(input [7:0] p, output [15:0] d);
    begin
      @(posedge clk_sys);
      #1 reg_rd = 1'b1;
      reg_ptr = p;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
    end
  endtask
endmodule // smbus_host_model

// ==== temp_sensor_capability_hysteresis.v ====
`timescale 1ns/1ps
`include "tsense_consts.vh"
// Contract
// - Capability read-only, upper byte zero
// - Freeze bit one: release alarm in shutdown
// - Freeze bit zero: hold alarm level
// - Capability bit 7 mirrors bus-control bit 4
// - Report time-out support, 25 to 35 ms
// - Time-out runs in shutdown too
// - Resolution field reads 10, eleven bits
// - Negative range bit reads one
// - Accuracy and alarm capability bits read one
// - Config bits 15:11 reserved, read zero
// - Hysteresis select 0/1.5/3/6 degrees
// - Above flag sets over upper limit
// - Above flag clears at limit minus hysteresis
// - Below flag clears at lower limit
// - Below flag sets at limit minus hysteresis
// - Alarm pin uses same thresholds
// - Locks block hysteresis writes
// - Shutdown stops conversions and alarms
// - Critical lock protects critical limit
// - Read-only writes ignored, write-only reads zero
module temp_sensor_capability_hysteresis #(
  parameter SAMPLE_CYC = `SAMPLE_CYC,
  parameter TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input wire clk_sys,
  input wire reset,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_ptr,
  input wire [15:0] reg_wdata,
  input wire bus_busy,
  input wire [12:0] adc_temp,
  output reg [15:0] reg_rdata,
  output reg bus_timeout,
  output reg alarm_out_o,
  output reg alarm_out_oe_n
);
  // ==========================================================
  // Registers
  reg [1:0] hyst_q;
  reg shdn_q;
  reg crit_lock_q;
  reg win_lock_q;
  reg out_en_q;
  reg [7:0] busctl_q;
  reg [12:0] upper_q;
  reg [12:0] lower_q;
  reg [12:0] crit_q;
  reg [12:0] temp_q;
  reg [31:0] samp_cnt_q;
  reg sample_q;
  reg sampled_q;
  reg shdn_prev_q;
  reg hold_q;
  reg [31:0] to_cnt_q;
  wire above;
  wire below;
  wire critf;
  wire locked = crit_lock_q | win_lock_q;
  wire freeze = busctl_q[`BUSCTL_FREEZE_BIT];
  // Capability mirrors bus-control freeze-select bit
  wire [15:0] cap_word = {8'h00, freeze, 1'b0, `CAP_LOW6};
  wire [15:0] cfg_word = {5'h00, hyst_q, shdn_q, crit_lock_q, win_lock_q, 2'h0, out_en_q, 3'h0};
  wire [15:0] cap_fix = cap_word | 16'h0040;
  // ==========================================================
  // Register writes
  always @(posedge clk_sys) begin
    if (reset) begin
      hyst_q <= 2'h0;
      shdn_q <= 1'b0;
      crit_lock_q <= 1'b0;
      win_lock_q <= 1'b0;
      out_en_q <= 1'b0;
      busctl_q <= `BUSCTL_RESET;
      upper_q <= 13'h0000;
      lower_q <= 13'h0000;
      crit_q <= 13'h0000;
    end else if (reg_wr) begin
      case (reg_ptr)
        `PTR_CFG: begin
          if (!locked) begin
            hyst_q <= reg_wdata[`CFG_HYST_HI:`CFG_HYST_LO];
          end
          // Shutdown may always be cleared but not set while locked
          if (!locked || !reg_wdata[`CFG_SHDN_BIT]) begin
            shdn_q <= reg_wdata[`CFG_SHDN_BIT];
          end
          crit_lock_q <= crit_lock_q | reg_wdata[`CFG_CRIT_LOCK_BIT];
          win_lock_q <= win_lock_q | reg_wdata[`CFG_WIN_LOCK_BIT];
          out_en_q <= reg_wdata[`CFG_OUTEN_BIT];
        end
        `PTR_UPPER: begin
          if (!win_lock_q) begin
            upper_q <= reg_wdata[12:0];
          end
        end
        `PTR_LOWER: begin
          if (!win_lock_q) begin
            lower_q <= reg_wdata[12:0];
          end
        end
        `PTR_CRIT: begin
          if (!crit_lock_q) begin
            crit_q <= reg_wdata[12:0];
          end
        end
        `PTR_BUSCTL: begin
          busctl_q <= reg_wdata[7:0];
        end
        default: begin
          // Capability, temperature and unknown pointers take no write
          upper_q <= upper_q;
        end
      endcase
    end
  end
  // ==========================================================
  // Conversion pacing, halted in shutdown
  always @(posedge clk_sys) begin
    if (reset) begin
      samp_cnt_q <= 32'h00000000;
      sample_q <= 1'b0;
      temp_q <= 13'h0000;
    end else if (shdn_q) begin
      samp_cnt_q <= 32'h00000000;
      sample_q <= 1'b0;
    end else if (samp_cnt_q == SAMPLE_CYC - 1) begin
      samp_cnt_q <= 32'h00000000;
      sample_q <= 1'b1;
      temp_q <= adc_temp;
    end else begin
      samp_cnt_q <= samp_cnt_q + 32'h00000001;
      sample_q <= 1'b0;
    end
  end
  // Flags clear on leaving shutdown so the first sample starts fresh
  window_compare #(
    .W(13)
  ) u_win (
    .clk_sys(clk_sys),
    .reset(reset),
    .sample(sample_q),
    .clear(shdn_prev_q & ~shdn_q),
    .hyst_sel(hyst_q),
    .temp(temp_q),
    .upper(upper_q),
    .lower(lower_q),
    .crit(crit_q),
    .above_q(above),
    .below_q(below),
    .crit_q(critf)
  );
  // ==========================================================
  // Alarm pin, open-drain, low-active enable
  always @(posedge clk_sys) begin
    if (reset) begin
      shdn_prev_q <= 1'b0;
      hold_q <= 1'b0;
      sampled_q <= 1'b0;
      alarm_out_o <= 1'b0;
      alarm_out_oe_n <= 1'b1;
    end else begin
      shdn_prev_q <= shdn_q;
      sampled_q <= sample_q;
      if (shdn_q && !shdn_prev_q) begin
        hold_q <= 1'b1;
        if (freeze) begin
          alarm_out_oe_n <= 1'b1;
        end
      end else if (sampled_q) begin
        hold_q <= 1'b0;
      end
      if (shdn_q || hold_q) begin
        // Frozen level stays; released pin stays released
        if (freeze) begin
          alarm_out_oe_n <= 1'b1;
        end else begin
          alarm_out_oe_n <= alarm_out_oe_n;
        end
      end else begin
        alarm_out_oe_n <= ~(out_en_q & (above | below | critf));
      end
      alarm_out_o <= 1'b0;
    end
  end
  // ==========================================================
  // Bus time-out, counts whenever the bus is held
  always @(posedge clk_sys) begin
    if (reset) begin
      to_cnt_q <= 32'h00000000;
      bus_timeout <= 1'b0;
    end else if (!bus_busy) begin
      to_cnt_q <= 32'h00000000;
      bus_timeout <= 1'b0;
    end else if (to_cnt_q == TIMEOUT_CYC - 1) begin
      bus_timeout <= 1'b1;
    end else begin
      to_cnt_q <= to_cnt_q + 32'h00000001;
      bus_timeout <= 1'b0;
    end
  end
  // ==========================================================
  // Read data
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_ptr)
        `PTR_CAP: reg_rdata <= cap_fix;
        `PTR_CFG: reg_rdata <= cfg_word;
        `PTR_UPPER: reg_rdata <= {3'h0, upper_q};
        `PTR_LOWER: reg_rdata <= {3'h0, lower_q};
        `PTR_CRIT: reg_rdata <= {3'h0, crit_q};
        `PTR_TEMP: reg_rdata <= {critf, above, below, temp_q};
        `PTR_BUSCTL: reg_rdata <= {8'h00, busctl_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // temp_sensor_capability_hysteresis

// ==== temp_sensor_capability_hysteresis_tb_top.sv ====
`timescale 1ns/1ps
// ====
// Bench top; rows are {op, ptr, data, expected}
module temp_sensor_capability_hysteresis_tb_top;
  localparam SAMPLE = 20;
  localparam NR = 66;
  // Critical limit is raised before the output is enabled, otherwise a zero limit trips on every sample
  localparam logic [43:0] rows [0:NR-1] = '{
    44'h10000000077, 44'h10100000000, 44'h000ffff0000, 44'h10000000077,
    44'h02200310000, 44'h100000000f7, 44'h02200210000, 44'h10000000077,
    44'h00104000000, 44'h10100000400, 44'h00106000000, 44'h10100000600,
    44'h00100200000, 44'h10100000000,
    44'h00201000000, 44'h00300800000, 44'h0040fff0000, 44'h00102080000, 44'h10100000208,
    44'h20000c00000, 44'h10500000000, 44'h30000000000,
    44'h20001010000, 44'h10500004000, 44'h30000000001,
    44'h20001000000, 44'h10500004000, 44'h20000f50000, 44'h10500004000,
    44'h20000f40000, 44'h10500000000, 44'h30000000000,
    44'h200007f0000, 44'h10500000000, 44'h20000740000, 44'h10500002000, 44'h30000000001,
    44'h200007f0000, 44'h10500002000, 44'h20000800000, 44'h10500000000,
    44'h00100080000, 44'h20001010000, 44'h10500004000, 44'h20001000000, 44'h10500000000,
    44'h20001010000, 44'h30000000001, 44'h02200310000, 44'h00101080000, 44'h30000000000,
    44'h40000180000, 44'h00100080000, 44'h30000000000, 44'h20001010000, 44'h30000000001,
    44'h02200210000, 44'h00101080000, 44'h30000000001, 44'h20000c00000, 44'h30000000001,
    44'h10500004000, 44'h00100080000, 44'h30000000001, 44'h20000c00000, 44'h30000000000};
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg bus_busy = 1'b0;
  reg [12:0] adc_temp = 13'h0000;
  wire reg_wr, reg_rd, bus_timeout, alarm_out_o, alarm_out_oe_n;
  wire [7:0] reg_ptr;
  wire [15:0] reg_wdata, reg_rdata;
  integer bad_count = 0;
  integer total_checks = 0;
  integer i;
  reg [15:0] got;
  always #10 clk_sys = ~clk_sys;
  temp_sensor_capability_hysteresis #(.SAMPLE_CYC(SAMPLE), .TIMEOUT_CYC(16)) dut (.clk_sys(clk_sys), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .bus_busy(bus_busy),
    .adc_temp(adc_temp), .reg_rdata(reg_rdata), .bus_timeout(bus_timeout), .alarm_out_o(alarm_out_o),
    .alarm_out_oe_n(alarm_out_oe_n));
  smbus_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_ptr(reg_ptr), .reg_wdata(reg_wdata));
  task check(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task pins(input [15:0] e);
    begin
      #1 check({13'h0, bus_timeout, alarm_out_o, alarm_out_oe_n}, e);
    end
  endtask
  // Sampling free-runs, so op 2 waits two full periods for a settled flag
  task run_row(input [43:0] r);
    reg [3:0] op;
    reg [7:0] p;
    reg [15:0] d, e;
    begin
      {op, p, d, e} = r;
      case (op)
        4'h0: host.wr(p, d);
        4'h1: begin
          host.rd(p, got);
          check(got & (p == 8'h05 ? 16'he000 : 16'hffff), e);
        end
        4'h2: begin
          @(posedge clk_sys);
          #1 adc_temp = d[12:0];
          repeat (2 * SAMPLE + 4) @(posedge clk_sys);
        end
        4'h3: begin
          repeat (3) @(posedge clk_sys);
          pins({15'h0, ~e[0]});
        end
        default: begin
          @(posedge clk_sys);
          #1 bus_busy = 1'b1;
          repeat (d) @(posedge clk_sys);
          pins({13'h0, 1'b1, 1'b0, ~e[0]});
          bus_busy = 1'b0;
          repeat (3) @(posedge clk_sys);
          pins({15'h0, ~e[0]});
        end
      endcase
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    pins(16'h0001);
    check(reg_rdata, 16'h0000);
    reset = 1'b0;
    for (i = 0; i < NR; i = i + 1) begin
      run_row(rows[i]);
    end
    host.wr(8'h01, 16'h0248);
    host.wr(8'h01, 16'h0648);
    host.rd(8'h01, got);
    check({14'h0, got[10:9]}, 16'h0001);
    @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    pins(16'h0001);
    check(reg_rdata, 16'h0000);
    reset = 1'b0;
    host.rd(8'h01, got);
    check(got, 16'h0000);
    host.wr(8'h01, 16'h0400);
    host.rd(8'h01, got);
    check(got, 16'h0400);
    wrap_up;
  end
endmodule // temp_sensor_capability_hysteresis_tb_top

// ==== tsense_checker.sv ====
`timescale 1ns/1ps
// ====
// Port checker
module tsense_checker #(
  parameter TIMEOUT_CYC = 16
) (
  input wire clk_sys,
  input wire reset,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_ptr,
  input wire [15:0] reg_wdata,
  input wire bus_busy,
  input wire [15:0] reg_rdata,
  input wire bus_timeout,
  input wire alarm_out_oe_n
);
  // Run of busy cycles; a margin of two keeps the registered flag legal
  reg [31:0] busy_q;
  wire [31:0] busy_d = bus_busy ? busy_q + 32'h1 : 32'h0;
  always @(posedge clk_sys) begin
    busy_q <= reset ? 32'h0 : busy_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_cap_upper_zero: assert property (reg_rd && reg_ptr == 8'h00 |=> reg_rdata[15:8] == 8'h00)
    else $error("cap upper byte set");
  chk_cap_fixed_bits: assert property (reg_rd && reg_ptr == 8'h00 |=> reg_rdata[6:0] == 7'h77)
    else $error("cap fixed bits wrong");
  chk_cfg_reserved_zero: assert property (reg_rd && reg_ptr == 8'h01 |=> reg_rdata[15:11] == 5'h00)
    else $error("cfg reserved bits set");
  chk_cfg_wo_zero: assert property (reg_rd && reg_ptr == 8'h01 |=> !reg_rdata[5])
    else $error("write-only bit read one");
  chk_cap_mirror: assert property ((reg_wr && reg_ptr == 8'h22) ##1 !reg_wr ##1 (reg_rd && reg_ptr == 8'h00)
    |=> reg_rdata[7] == $past(reg_wdata[4], 3))
    else $error("cap bit 7 not mirrored");
  chk_timeout_early: assert property (bus_busy && busy_q >= 2 && busy_q + 2 < TIMEOUT_CYC |-> !bus_timeout)
    else $error("timeout too early");
  chk_timeout_late: assert property (busy_q > TIMEOUT_CYC + 1 |-> bus_timeout)
    else $error("timeout missing");
  chk_timeout_clear: assert property ($fell(bus_busy) |=> !bus_timeout)
    else $error("timeout not cleared");
  cover property (bus_timeout);
  cover property (reg_rd && reg_ptr == 8'h05);
  cover property ($fell(alarm_out_oe_n));
endmodule // tsense_checker

bind temp_sensor_capability_hysteresis tsense_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.clk_sys(clk_sys),
  .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
  .bus_busy(bus_busy), .reg_rdata(reg_rdata), .bus_timeout(bus_timeout), .alarm_out_oe_n(alarm_out_oe_n));

// ==== tsense_consts.vh ====
`ifndef TSENSE_CONSTS_VH
`define TSENSE_CONSTS_VH
// ==========================================================
// Register pointers
`define PTR_CAP 8'h00
`define PTR_CFG 8'h01
`define PTR_UPPER 8'h02
`define PTR_LOWER 8'h03
`define PTR_CRIT 8'h04
`define PTR_TEMP 8'h05
`define PTR_BUSCTL 8'h22
// ==========================================================
// Capability fields
`define CAP_ALARM_OUT_SHUTDOWN_BEHAVIOUR_BIT 7
`define CAP_LOW6 6'h37
// ==========================================================
// Configuration fields
`define CFG_HYST_HI 10
`define CFG_HYST_LO 9
`define CFG_SHDN_BIT 8
`define CFG_CRIT_LOCK_BIT 7
`define CFG_WIN_LOCK_BIT 6
`define CFG_OUTEN_BIT 3
`define BUSCTL_FREEZE_BIT 4
`define BUSCTL_RESET 8'h21
// ==========================================================
// Temperature word flags
`define TEMP_ABOVE_BIT 14
`define TEMP_BELOW_BIT 13
`define TEMP_CRIT_BIT 15
// ==========================================================
// Hysteresis in 1/8 degree steps
`define HYST_1P5 13'h000c
`define HYST_3 13'h0018
`define HYST_6 13'h0030
// ==========================================================
// Timing
`define CLK_HZ 50000000
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_MAX_MS 35
`define TIMEOUT_CYC ((`TIMEOUT_MIN_MS * `CLK_HZ / 1000 + `TIMEOUT_MAX_MS * `CLK_HZ / 1000) / 2)
`define SAMPLE_CYC 5000000
`endif

// ==== window_compare.v ====
`timescale 1ns/1ps
`include "tsense_consts.vh"
// ==========================================================
// Window flag update with hysteresis, one sample at a time
module window_compare #(
  parameter W = 13
) (
  input wire clk_sys,
  input wire reset,
  input wire sample,
  input wire clear,
  input wire [1:0] hyst_sel,
  input wire signed [W-1:0] temp,
  input wire signed [W-1:0] upper,
  input wire signed [W-1:0] lower,
  input wire signed [W-1:0] crit,
  output reg above_q,
  output reg below_q,
  output reg crit_q
);
  function [W-1:0] hyst_steps;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: hyst_steps = `HYST_1P5;
        2'h2: hyst_steps = `HYST_3;
        2'h3: hyst_steps = `HYST_6;
        default: hyst_steps = {W{1'b0}};
      endcase
    end
  endfunction
  wire signed [W-1:0] h = hyst_steps(hyst_sel);
  wire signed [W:0] up_rel = {upper[W-1], upper} - {h[W-1], h};
  wire signed [W:0] lo_rel = {lower[W-1], lower} - {h[W-1], h};
  wire signed [W:0] cr_rel = {crit[W-1], crit} - {h[W-1], h};
  wire signed [W:0] t = {temp[W-1], temp};
  always @(posedge clk_sys) begin
    if (reset || clear) begin
      above_q <= 1'b0;
      below_q <= 1'b0;
      crit_q <= 1'b0;
    end else if (sample) begin
      if (temp > upper) begin
        above_q <= 1'b1;
      end else if (t <= up_rel) begin
        above_q <= 1'b0;
      end
      if (temp >= lower) begin
        below_q <= 1'b0;
      end else if (t <= lo_rel) begin
        below_q <= 1'b1;
      end
      if (temp >= crit) begin
        crit_q <= 1'b1;
      end else if (t <= cr_rel) begin
        crit_q <= 1'b0;
      end
    end
  end
endmodule // window_compare
